// >>> design/mts_defs.svh
`ifndef MTS_DEFS_SVH
`define MTS_DEFS_SVH
`define MTS_ADDR_SRC      12'h000
`define MTS_ADDR_CTRL     12'h004
`define MTS_ADDR_VTHR     12'h008
`define MTS_ADDR_ITHR     12'h00c
`define MTS_ADDR_VFS      12'h010
`define MTS_ADDR_IFS      12'h014
`define MTS_ADDR_CMD      12'h018
`define MTS_ADDR_STAT     12'h01c
`define MTS_ADDR_PINS     12'h020
`define MTS_CTRL_FWD_BIT  0
`define MTS_CTRL_VSLP_BIT 1
`define MTS_CTRL_ISLP_BIT 2
`define MTS_CMD_TRIG_BIT  0
`define MTS_CMD_INIT_BIT  1
`define MTS_CMD_ABORT_BIT 2
`define MTS_THR_MIN       16'h0000
`define MTS_VFS_RST       16'hffff
`define MTS_IFS_RST       16'hffff
// Hysteresis = full scale * 0.0005 = full scale * 1 / 2000
`define MTS_HYST_DIV      32'd2000
`endif

// >>> design/mts_level_det.sv
`timescale 1ns/1ps
// One level comparator with rising/falling select and hysteresis taken from the hyst input
module mts_level_det
  import mts_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic [15:0] sample,
  input  wire logic [15:0] threshold,
  input  wire logic [15:0] hyst,
  input  wire logic        falling,
  output logic             fire
);
  mts_lvl_type st_q;
  mts_lvl_type st_d;
  logic [16:0] rearm_hi;
  logic [16:0] rearm_lo;
  logic        past;
  logic        back;

  always_comb
  begin
    rearm_hi = {1'b0, threshold} + {1'b0, hyst};
    rearm_lo = {1'b0, threshold} - {1'b0, hyst};
    // Underflow of rearm_lo shows in bit 16; then nothing is below it
    past = falling ? (sample <= threshold) : (sample >= threshold);
    back = falling ? ({1'b0, sample} >= rearm_hi)
                   : (!rearm_lo[16] && ({1'b0, sample} <= rearm_lo));
    st_d = st_q;
    st_d.fire = 1'b0;
    if (st_q.armed && past)
    begin
      st_d.fire  = 1'b1;
      st_d.armed = 1'b0;
    end
    else if (!st_q.armed && back)
    begin
      st_d.armed = 1'b1;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  assign fire = st_q.fire;
endmodule : mts_level_det

// >>> design/mts_pkg.sv
package mts_pkg;
  typedef enum logic [2:0] {
    MTS_SRC_BUS, MTS_SRC_CURR, MTS_SRC_EXT, MTS_SRC_PIN, MTS_SRC_TRAN, MTS_SRC_VOLT
  } mts_src_type;
  typedef struct packed {
    mts_src_type kind;
    logic [2:0]  index;
  } mts_sel_type;
  typedef struct packed {
    logic [3:0][15:0] volt;
    logic [3:0][15:0] curr;
  } mts_meas_type;
  typedef struct packed {
    logic        armed;
    logic        fire;
  } mts_lvl_type;
endpackage : mts_pkg

// >>> design/mts_trigger_select.sv
// The implementer's own choices: register access over APB and the address map.
`timescale 1ns/1ps
`include "mts_defs.svh"
// Measurement trigger select for one channel, APB register access
module mts_trigger_select
  import mts_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire mts_meas_type meas,
  input  wire logic [3:0]  tran_event,
  input  wire logic [6:0]  pin_in,
  input  wire logic [6:0]  pin_is_trig_in,
  input  wire logic [6:0]  pin_is_trig_out,
  input  wire logic        ext_trig_any,
  input  wire logic        meas_done,
  output logic             meas_trigger,
  output logic             meas_active,
  output logic             waiting_for_measure_trigger_bit,
  output logic [6:0]       pin_trig_out
);
  typedef struct packed {
    mts_sel_type measure_trigger_source_select;
    logic        trigger_forward_enable;
    logic        volt_falling;
    logic        current_crossing_direction;
    logic [15:0] voltage_threshold_setting;
    logic [15:0] current_threshold_setting;
    logic [15:0] volt_full_scale;
    logic [15:0] curr_full_scale;
    logic        active;
    logic        waiting;
    logic        trig;
    logic [6:0]  pin_out;
    logic [6:0]  pin_prev;
    logic [6:0]  pin_last;
    logic [31:0] rdata;
    logic        ready;
    logic        err;
  } mts_state_type;

  mts_state_type st_q;
  mts_state_type st_d;
  logic [15:0]   v_sample;
  logic [15:0]   i_sample;
  logic [15:0]   v_hyst;
  logic [15:0]   i_hyst;
  logic          v_fire;
  logic          i_fire;
  logic          bus_trig;
  logic          src_event;
  logic          setup;
  logic          wr_access;
  logic          sel_ok;
  logic [2:0]    ch;
  logic [2:0]    pidx;

  // Channel index 1..4 maps to samples 0..3
  assign ch       = st_q.measure_trigger_source_select.index - 3'd1;
  assign v_sample = meas.volt[ch[1:0]];
  assign i_sample = meas.curr[ch[1:0]];
  assign v_hyst   = 16'((32'(st_q.volt_full_scale)) / `MTS_HYST_DIV);
  assign i_hyst   = 16'((32'(st_q.curr_full_scale)) / `MTS_HYST_DIV);

  // Hazard: comparator state tracks whichever channel is selected now
  mts_level_det u_vdet (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .sample    (v_sample),
    .threshold (st_q.voltage_threshold_setting),
    .hyst      (v_hyst),
    .falling   (st_q.volt_falling),
    .fire      (v_fire)
  );
  mts_level_det u_idet (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .sample    (i_sample),
    .threshold (st_q.current_threshold_setting),
    .hyst      (i_hyst),
    .falling   (st_q.current_crossing_direction),
    .fire      (i_fire)
  );

  assign setup     = psel && !penable;
  assign wr_access = psel && penable && pwrite && st_q.ready;
  assign bus_trig  = wr_access && paddr == `MTS_ADDR_CMD && pwdata[`MTS_CMD_TRIG_BIT];
  assign pidx      = st_q.measure_trigger_source_select.index - 3'd1;

  // Source selection: pin, current, transient and voltage check their index ranges; bus and external take any index
  always_comb
  begin
    sel_ok = 1'b0;
    case (mts_src_type'(pwdata[6:4]))
      MTS_SRC_BUS:  sel_ok = 1'b1;
      MTS_SRC_EXT:  sel_ok = 1'b1;
      MTS_SRC_PIN:  sel_ok = pwdata[2:0] >= 3'd1;
      MTS_SRC_CURR: sel_ok = pwdata[2:0] >= 3'd1 && pwdata[2:0] <= 3'd4;
      MTS_SRC_TRAN: sel_ok = pwdata[2:0] >= 3'd1 && pwdata[2:0] <= 3'd4;
      MTS_SRC_VOLT: sel_ok = pwdata[2:0] >= 3'd1 && pwdata[2:0] <= 3'd4;
      default:      sel_ok = 1'b0;
    endcase
  end

  always_comb
  begin
    src_event = 1'b0;
    case (st_q.measure_trigger_source_select.kind)
      MTS_SRC_BUS:  src_event = bus_trig;
      MTS_SRC_CURR: src_event = i_fire;
      MTS_SRC_VOLT: src_event = v_fire;
      MTS_SRC_EXT:  src_event = ext_trig_any || |(pin_in & pin_is_trig_in);
      MTS_SRC_PIN:  src_event = pin_is_trig_in[pidx] && pin_in[pidx]
                                && !st_q.pin_prev[pidx];
      MTS_SRC_TRAN: src_event = tran_event[ch[1:0]];
      default:      src_event = 1'b0;
    endcase
  end

  always_comb
  begin
    st_d          = st_q;
    st_d.ready    = setup;
    st_d.err      = 1'b0;
    st_d.trig     = src_event;
    st_d.pin_prev = pin_in;
    // Every event while active is forwarded, not only the first
    st_d.pin_out  = (st_q.trigger_forward_enable && st_q.active && src_event)
                    ? pin_is_trig_out : 7'h00;
    if (src_event && st_q.active)
      st_d.waiting = 1'b0;
    // The pulse is gone before software can read it; keep the last pattern
    if (st_d.pin_out != 7'h00)
      st_d.pin_last = st_d.pin_out;
    // Decode in setup so data and error stand with pready in the access cycle
    if (setup)
    begin
      st_d.rdata = 32'h0;
      if (paddr == `MTS_ADDR_SRC)
      begin
        st_d.rdata[6:0] = {st_q.measure_trigger_source_select.kind, 1'b0,
                           st_q.measure_trigger_source_select.index};
        st_d.err        = pwrite && !sel_ok;
      end
      else if (paddr == `MTS_ADDR_CTRL)
      begin
        st_d.rdata[2:0] = {st_q.current_crossing_direction, st_q.volt_falling,
                           st_q.trigger_forward_enable};
      end
      else if (paddr == `MTS_ADDR_VTHR)
      begin
        st_d.rdata[15:0] = st_q.voltage_threshold_setting;
      end
      else if (paddr == `MTS_ADDR_ITHR)
      begin
        st_d.rdata[15:0] = st_q.current_threshold_setting;
      end
      else if (paddr == `MTS_ADDR_VFS)
      begin
        st_d.rdata[15:0] = st_q.volt_full_scale;
      end
      else if (paddr == `MTS_ADDR_IFS)
      begin
        st_d.rdata[15:0] = st_q.curr_full_scale;
      end
      else if (paddr == `MTS_ADDR_CMD)
      begin
        st_d.rdata = 32'h0;
      end
      else if (paddr == `MTS_ADDR_STAT)
      begin
        st_d.rdata[1:0] = {st_q.waiting, st_q.active};
      end
      else if (paddr == `MTS_ADDR_PINS)
      begin
        st_d.rdata[6:0] = st_q.pin_last;
      end
      else
      begin
        st_d.err = 1'b1;
      end
    end
    // Writes land only at the access edge; a refused source code keeps the old one
    if (wr_access)
    begin
      if (paddr == `MTS_ADDR_SRC)
      begin
        if (sel_ok)
          st_d.measure_trigger_source_select = mts_sel_type'({pwdata[6:4], pwdata[2:0]});
      end
      else if (paddr == `MTS_ADDR_CTRL)
      begin
        st_d.trigger_forward_enable     = pwdata[`MTS_CTRL_FWD_BIT];
        st_d.volt_falling               = pwdata[`MTS_CTRL_VSLP_BIT];
        st_d.current_crossing_direction = pwdata[`MTS_CTRL_ISLP_BIT];
      end
      else if (paddr == `MTS_ADDR_VTHR)
        st_d.voltage_threshold_setting = pwdata[15:0];
      else if (paddr == `MTS_ADDR_ITHR)
        st_d.current_threshold_setting = pwdata[15:0];
      else if (paddr == `MTS_ADDR_VFS)
        st_d.volt_full_scale = pwdata[15:0];
      else if (paddr == `MTS_ADDR_IFS)
        st_d.curr_full_scale = pwdata[15:0];
      else if (paddr == `MTS_ADDR_CMD)
      begin
        if (pwdata[`MTS_CMD_INIT_BIT])
        begin
          st_d.active  = 1'b1;
          st_d.waiting = 1'b1;
        end
        if (pwdata[`MTS_CMD_ABORT_BIT])
        begin
          st_d.active  = 1'b0;
          st_d.waiting = 1'b0;
        end
      end
    end
    // Completion wins over a same-cycle initiate; the run has ended
    if (meas_done)
    begin
      st_d.active                 = 1'b0;
      st_d.waiting                = 1'b0;
      st_d.trigger_forward_enable = 1'b0;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      st_q <= '0;
      st_q.measure_trigger_source_select.kind <= MTS_SRC_BUS;
      st_q.voltage_threshold_setting <= `MTS_THR_MIN;
      st_q.current_threshold_setting <= `MTS_THR_MIN;
      st_q.volt_full_scale <= `MTS_VFS_RST;
      st_q.curr_full_scale <= `MTS_IFS_RST;
    end
    else
      st_q <= st_d;
  end

  assign prdata                          = st_q.rdata;
  assign pready                          = st_q.ready;
  assign pslverr                         = st_q.err;
  assign meas_trigger                    = st_q.trig;
  assign meas_active                     = st_q.active;
  assign waiting_for_measure_trigger_bit = st_q.waiting;
  assign pin_trig_out                    = st_q.pin_out;
endmodule : mts_trigger_select

// >>> tb/mts_host_model.sv
`timescale 1ns/1ps
`include "mts_defs.svh"
module mts_host_model
(
  input  wire logic        core_clk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [11:0] paddr,
  output logic      [31:0] pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
  end
  // Entered just after a rising edge
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Released lines flip so a stale value never looks live
    paddr <= ~a;
    pwdata <= ~d;
    @(posedge core_clk);
  endtask : xfer
  task automatic cfg_level(input logic [31:0] src, input logic [11:0] ta,
                           input logic [31:0] thr, input logic [31:0] ctrl);
    logic [31:0] r;
    logic        e;
    xfer(1'b1, `MTS_ADDR_SRC, src, r, e);
    xfer(1'b1, ta, thr, r, e);
    xfer(1'b1, `MTS_ADDR_CTRL, ctrl, r, e);
    xfer(1'b1, `MTS_ADDR_VFS, 32'h0000_4e20, r, e);
    xfer(1'b1, `MTS_ADDR_IFS, 32'h0000_4e20, r, e);
  endtask : cfg_level
endmodule : mts_host_model

// >>> tb/mts_trigger_select_sva.sv
`timescale 1ns/1ps
`include "mts_defs.svh"
module mts_trigger_select_chk
  import mts_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        rst_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        meas_done,
  input wire logic [6:0]  pin_is_trig_out,
  input wire logic        meas_trigger,
  input wire logic        meas_active,
  input wire logic        waiting_for_measure_trigger_bit,
  input wire logic [6:0]  pin_trig_out
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  logic cmd_wr;
  assign cmd_wr = psel && penable && pready && pwrite && paddr == `MTS_ADDR_CMD;
  chk_pready_single: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  chk_pready_setup: assert property (psel && !penable |=> pready)
    else $error("no answer in the access cycle");
  chk_fwd_gate: assert property (|pin_trig_out |-> $past(meas_active))
    else $error("trigger forwarded while idle");
  chk_fwd_mask: assert property ((pin_trig_out & ~$past(pin_is_trig_out)) == 7'h00)
    else $error("forwarded to a pin not set as output");
  chk_fwd_with_trig: assert property (|pin_trig_out |-> meas_trigger)
    else $error("forward pulse without trigger");
  chk_done_clears: assert property (meas_done |=> !meas_active && !waiting_for_measure_trigger_bit)
    else $error("done left measurement flags set");
  chk_init_sets: assert property (cmd_wr && pwdata[1] && !pwdata[2] && !meas_done
    |=> meas_active && waiting_for_measure_trigger_bit) else $error("initiate not taken");
  chk_wait_clear: assert property (meas_trigger && $past(meas_active) && !$past(cmd_wr)
    |-> !waiting_for_measure_trigger_bit) else $error("waiting bit kept after trigger");
  cover property (cmd_wr && pwdata[0]);
  cover property (|pin_trig_out);
  cover property (meas_done && meas_active);
endmodule : mts_trigger_select_chk

bind mts_trigger_select mts_trigger_select_chk u_chk (
  .core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .meas_done(meas_done),
  .pin_is_trig_out(pin_is_trig_out), .meas_trigger(meas_trigger), .meas_active(meas_active),
  .waiting_for_measure_trigger_bit(waiting_for_measure_trigger_bit),
  .pin_trig_out(pin_trig_out)
);

// >>> tb/tb_top.sv
`timescale 1ns/1ps
`include "mts_defs.svh"
module tb_top
  import mts_pkg::*;
;
  logic         core_clk, rst_n, psel, penable, pwrite, pready, pslverr, err;
  logic         ext_trig_any, meas_done, meas_trigger, meas_active, wait_bit;
  logic [11:0]  paddr;
  logic [31:0]  pwdata, prdata, rd, last, ev;
  logic [6:0]   pin_in, pin_is_trig_in, pin_is_trig_out, pin_trig_out;
  logic [3:0]   tran_event;
  mts_meas_type meas;
  int           bad_count, compares, trig_cnt, fwd_cnt, tr_exp, fw_exp, p, c;

  mts_trigger_select u_mts_trigger_select (
    .core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .meas(meas), .tran_event(tran_event), .pin_in(pin_in), .pin_is_trig_in(pin_is_trig_in),
    .pin_is_trig_out(pin_is_trig_out), .ext_trig_any(ext_trig_any), .meas_done(meas_done),
    .meas_trigger(meas_trigger), .meas_active(meas_active),
    .waiting_for_measure_trigger_bit(wait_bit), .pin_trig_out(pin_trig_out));
  mts_host_model u_mts_host_model (
    .core_clk(core_clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk)
  begin
    if (meas_trigger === 1'b1) trig_cnt++;
    if (pin_trig_out !== 7'h00) fwd_cnt++;
  end
  task automatic summarize();
    if (bad_count == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : summarize
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    u_mts_host_model.xfer(1'b1, a, d, rd, err);
  endtask : wr
  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    u_mts_host_model.xfer(1'b0, a, 32'h0, rd, err);
    chk(rd, e);
  endtask : rdc
  function automatic logic [31:0] src_code(input logic [2:0] k, input logic [2:0] i);
    logic ok;
    case (k)
      3'd0, 3'd2: ok = (i == 3'd0);
      3'd3: ok = (i != 3'd0);
      3'd1, 3'd4, 3'd5: ok = (i >= 3'd1 && i <= 3'd4);
      default: ok = 1'b0;
    endcase
    return ok ? {25'h0, k, 1'b0, i} : 32'hffff_ffff;
  endfunction : src_code
  task automatic fire(input int sel, input logic [6:0] b);
    @(posedge core_clk);
    if (sel == 0) ext_trig_any <= 1'b1;
    if (sel == 1) tran_event <= b[3:0];
    if (sel == 2) pin_in <= b;
    @(posedge core_clk);
    ext_trig_any <= 1'b0;
    tran_event <= 4'h0;
    pin_in <= 7'h00;
    repeat (4) @(posedge core_clk);
  endtask : fire
  task automatic tally(input int dt, input int df);
    tr_exp += dt;
    fw_exp += df;
    chk(trig_cnt, tr_exp);
    chk(fwd_cnt, fw_exp);
  endtask : tally
  task automatic done_chk(input logic [31:0] ctrl);
    @(posedge core_clk);
    meas_done <= 1'b1;
    @(posedge core_clk);
    meas_done <= 1'b0;
    rdc(`MTS_ADDR_CTRL, ctrl & 32'hffff_fffe);
    rdc(`MTS_ADDR_STAT, 32'h0);
  endtask : done_chk
  task automatic lvl(input logic cu, input logic fall);
    mts_meas_type m;
    int           d[7] = '{-20, 0, 5, -9, 0, -20, 3};
    logic [1:0]   ch;
    logic [15:0]  t, s;
    logic [31:0]  ctrl;
    ch = 2'($urandom_range(3));
    t = 16'($urandom_range(60000, 40));
    ctrl = {29'h0, cu & fall, !cu & fall, 1'b1};
    u_mts_host_model.cfg_level({25'h0, cu ? 3'd1 : 3'd5, 1'b0, 3'(ch) + 3'd1},
                               cu ? `MTS_ADDR_ITHR : `MTS_ADDR_VTHR, {16'h0, t}, ctrl);
    wr(`MTS_ADDR_CMD, 32'h2);
    for (int i = 0; i < 7; i++)
    begin
      s = fall ? t - 16'(d[i]) : t + 16'(d[i]);
      m = {$urandom, $urandom, $urandom, $urandom};
      if (cu) m.curr[ch] = s;
      else m.volt[ch] = s;
      @(posedge core_clk);
      meas <= m;
      repeat (5) @(posedge core_clk);
      if (i == 0) tr_exp = trig_cnt;
      if (i == 0) fw_exp = fwd_cnt;
    end
    tally(2, 2);
    done_chk(ctrl);
  endtask : lvl

  initial
  begin
    repeat (30000) @(posedge core_clk);
    bad_count++;
    summarize();
  end
  initial
  begin
    {rst_n, ext_trig_any, meas_done, pin_in, tran_event, meas} = '0;
    {bad_count, compares, trig_cnt, fwd_cnt} = '0;
    last = $urandom(32'h9e016f6a);
    p = $urandom_range(6);
    c = $urandom_range(3);
    pin_is_trig_in = 7'($urandom) | (7'h01 << p);
    pin_is_trig_out = 7'($urandom_range(127, 1));
    repeat (16) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    rdc(`MTS_ADDR_SRC, 32'h0);
    rdc(`MTS_ADDR_CTRL, 32'h0);
    rdc(`MTS_ADDR_VTHR, 32'h0);
    rdc(`MTS_ADDR_ITHR, 32'h0);
    u_mts_host_model.xfer(1'b0, 12'h040, 32'h0, rd, err);
    chk({31'h0, err}, 32'h1);
    last = 32'h0;
    for (int k = 0; k < 8; k++)
      for (int i = 0; i < 8; i++)
      begin
        if ((k == 0 || k == 2) && i != 0) continue;
        ev = src_code(k[2:0], i[2:0]);
        wr(`MTS_ADDR_SRC, {25'h0, k[2:0], 1'b0, i[2:0]});
        chk({31'h0, err}, {31'h0, ev[31]});
        if (!ev[31]) last = ev;
        rdc(`MTS_ADDR_SRC, last);
      end
    wr(`MTS_ADDR_SRC, 32'h0);
    wr(`MTS_ADDR_CTRL, 32'h1);
    wr(`MTS_ADDR_CMD, 32'h2);
    rdc(`MTS_ADDR_STAT, 32'h3);
    tr_exp = trig_cnt;
    fw_exp = fwd_cnt;
    fire(0, 7'h00);
    wr(`MTS_ADDR_CMD, 32'h1);
    repeat (3) @(posedge core_clk);
    tally(1, 1);
    rdc(`MTS_ADDR_STAT, 32'h1);
    rdc(`MTS_ADDR_PINS, {25'h0, pin_is_trig_out});
    wr(`MTS_ADDR_SRC, 32'h20);
    fire(0, 7'h00);
    tally(1, 1);
    wr(`MTS_ADDR_SRC, {25'h0, 3'd3, 1'b0, 3'(p + 1)});
    fire(2, 7'h01 << ((p + 1) % 7));
    tally(0, 0);
    fire(2, 7'h01 << p);
    tally(1, 1);
    wr(`MTS_ADDR_SRC, {25'h0, 3'd4, 1'b0, 3'(c + 1)});
    fire(1, 7'h01 << ((c + 1) % 4));
    tally(0, 0);
    fire(1, 7'h01 << c);
    fire(1, 7'h01 << c);
    tally(2, 2);
    done_chk(32'h1);
    wr(`MTS_ADDR_CTRL, 32'h1);
    fire(1, 7'h01 << c);
    tally(1, 0);
    for (int k = 0; k < 4; k++)
      lvl(k[1], k[0]);
    summarize();
  end
endmodule : tb_top
